// >>> pkg/sas_pkg.sv
// Constants and types for the converter sequencer.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package sas_pkg;
   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam int         AXI_AW     = 5;
   localparam logic [4:0] OFF_CTRL   = 5'h00;
   localparam logic [4:0] OFF_CHAN   = 5'h04;
   localparam logic [4:0] OFF_TRIG   = 5'h08;
   localparam logic [4:0] OFF_RES_LO = 5'h0c;
   localparam logic [4:0] OFF_RES_HI = 5'h10;
   // Control and status field positions
   localparam int CTL_EN    = 7;
   localparam int CTL_START = 6;
   localparam int CTL_AUTO  = 5;
   localparam int CTL_DONE  = 4;
   localparam int CTL_IE    = 3;
   // Channel select field positions
   localparam int CH_ADJ    = 5;
   localparam int CH_REF    = 6;
   // ************************************************************
   // Timing in converter half cycles, trigger sync in system cycles
   // ************************************************************
   localparam logic [5:0] H_NORM_END  = 6'h1a; // 13 cycles
   localparam logic [5:0] H_FIRST_END = 6'h32; // 25 cycles
   localparam logic [5:0] H_AUTO_END  = 6'h1b; // 13.5 cycles
   localparam logic [5:0] H_DIFF_END  = 6'h1c; // 14 cycles
   localparam logic [5:0] H_NORM_SH   = 6'h03; // 1.5 cycles
   localparam logic [5:0] H_FIRST_SH  = 6'h1b; // 13.5 cycles
   localparam logic [5:0] H_AUTO_SH   = 6'h04; // 2 cycles
   localparam logic [5:0] H_DIFF_SH   = 6'h05; // 2.5 cycles
   localparam logic [5:0] H_LAST_CYC  = 6'h02; // One converter cycle
   localparam logic [1:0] TRIG_SYNC_LAST = 2'h2; // Three system cycles
   // ************************************************************
   // Channel codes and bus answers
   // ************************************************************
   localparam logic [4:0] SE_LAST      = 5'h07;
   localparam logic [4:0] GAIN10_FIRST = 5'h08;
   localparam logic [4:0] GAIN200_FIRST = 5'h0c;
   localparam logic [4:0] GAIN_LAST    = 5'h0f;
   localparam logic [1:0] GAIN_1X      = 2'h0;
   localparam logic [1:0] GAIN_10X     = 2'h1;
   localparam logic [1:0] GAIN_200X    = 2'h2;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   typedef enum logic [1:0] {SAS_IDLE, SAS_WAIT_EDGE, SAS_CONV} sas_conv_t;
endpackage

// >>> logic/sas_top.sv
// Converter sequencer: prescaler, start logic, timing, result lock.
// Assumes trigger sources come from logic on the same system clock.
//
// How it works
// - Result shown across two bytes, right adjusted, or left when selected.
// - Reading low byte freezes both bytes until high byte read.
// - Done flag still rises when a locked result is dropped.
// - Start bit reads one during any conversion, cleared at completion.
// - Channel change mid-conversion applies only afterwards.
// - Auto trigger rising edge resets prescaler and starts conversion.
// - Edges during conversion ignored; a held-high trigger restarts nothing.
// - Trigger flag must be cleared by software before next event.
// - Own done flag as trigger gives back-to-back conversions.
// - Start bit still gives single conversion with auto trigger on.
// - Prescaler runs while enabled, held in reset while disabled.
// - Software start begins at next rising converter clock edge.
// - Normal conversion 13 cycles, first after enable 25 cycles.
// - Sample and hold at 1.5 cycles, or 13.5 on first conversion.
// - At end write result, set done flag, clear start in single mode.
// - Auto-triggered: hold at 2 cycles, 13.5 total, 3 sync cycles.
// - Differential auto-triggered runs need disable and re-enable each time.
// - Free running restarts at once and keeps start bit high.
// - Selections take no effect and power is off while disabled.
// - Gain stage 1x/10x/200x for differential, bypass for single-ended.
// - Differential start with half-rate clock high lasts 14 cycles.
// - Selection locked at start, tracking again in final cycle.
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sas_top
   import sas_pkg::*;
(
   input  wire logic                clk_sys_i,     // 20 MHz system clock
   input  wire logic                nrst_i,        // Sync reset, active low
   input  wire logic [sas_pkg::AXI_AW-1:0] s_axi_awaddr, // Write address
   input  wire logic                s_axi_awvalid, // Write address valid
   output logic                     s_axi_awready, // Write address ready
   input  wire logic [31:0]         s_axi_wdata,   // Write data
   input  wire logic [3:0]          s_axi_wstrb,   // Write byte enables
   input  wire logic                s_axi_wvalid,  // Write data valid
   output logic                     s_axi_wready,  // Write data ready
   output logic [1:0]               s_axi_bresp,   // Write response
   output logic                     s_axi_bvalid,  // Write response valid
   input  wire logic                s_axi_bready,  // Write response ready
   input  wire logic [sas_pkg::AXI_AW-1:0] s_axi_araddr, // Read address
   input  wire logic                s_axi_arvalid, // Read address valid
   output logic                     s_axi_arready, // Read address ready
   output logic [31:0]              s_axi_rdata,   // Read data
   output logic [1:0]               s_axi_rresp,   // Read response
   output logic                     s_axi_rvalid,  // Read data valid
   input  wire logic                s_axi_rready,  // Read data ready
   input  wire logic [6:0]          trig_src_i,    // Trigger sources 1..7
   input  wire logic [9:0]          result_i,      // Comparator array code
   output logic                     power_en_o,    // Analog power on
   output logic [4:0]               mux_sel_o,     // Applied channel
   output logic [1:0]               ref_sel_o,     // Applied reference
   output logic [1:0]               gain_sel_o,    // Gain stage setting
   output logic                     gain_bypass_o, // Gain stage bypassed
   output logic                     sample_hold_o, // Hold pulse
   output logic                     adc_clk_o,     // Converter clock level
   output logic                     conv_busy_o,   // Conversion running
   output logic                     done_irq_o     // Done interrupt request
);
   import sas_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic       aw_got;
      logic [4:0] awaddr;
      logic       w_got;
      logic [7:0] wdata;
      logic       wstb;
      logic       awrdy;
      logic       wrdy;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arrdy;
      logic       rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic       en;
      logic       start_req;
      logic       auto;
      logic       done;
      logic       ie;
      logic [2:0] div;
      logic [4:0] ch;
      logic       adj;
      logic [1:0] refs;
      logic [2:0] tsrc;
      logic       lock;
      logic [9:0] res;
      logic       first;
      logic [7:0] pre;
      logic       hr;
      logic       aclk;
      sas_conv_t  cs;
      logic [5:0] half;
      logic [5:0] end_h;
      logic [5:0] sh_h;
      logic [1:0] sync;
      logic       trig_prev;
      logic [4:0] live_ch;
      logic [1:0] live_ref;
      logic       sh;
      logic       sh_seen;
      logic       irq;
      logic       busy;
      logic [1:0] gain;
      logic       bypass;
   } sas_state_t;

   sas_state_t st_ff;
   sas_state_t nxt_st;

   logic [2:0] shamt;
   logic [7:0] div_m1;
   logic [7:0] half_m1;
   logic       rise;
   logic       fall;
   logic       tsig;
   logic       tedge;
   logic       diff;
   logic       complete;
   logic       final_cyc;
   logic       start_view;
   logic [7:0] res_lo;
   logic [7:0] res_hi;

   // Timing pick: {end, sample point} in half cycles
   function automatic logic [11:0] sas_timing(input logic first,
                                              input logic auto,
                                              input logic dif,
                                              input logic hr);
      logic [11:0] t;
      t = {H_NORM_END, H_NORM_SH};
      if (first)
         t = {H_FIRST_END, H_FIRST_SH};
      else if (auto)
         t = {H_AUTO_END, H_AUTO_SH};
      else if (dif && hr)
         t = {H_DIFF_END, H_DIFF_SH};
      return t;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.sh = 1'b0;
      complete = 1'b0;
      // power of two divider, at least two
      shamt = (st_ff.div == 3'h0) ? 3'h1 : st_ff.div;
      div_m1 = (8'h01 << shamt) - 8'h01;
      half_m1 = (8'h01 << (shamt - 3'h1)) - 8'h01;
      rise = st_ff.en && (st_ff.pre == div_m1);
      fall = st_ff.en && (st_ff.pre == half_m1);
      diff = (st_ff.ch > SE_LAST);
      final_cyc = (st_ff.half >= st_ff.end_h - H_LAST_CYC);
      start_view = st_ff.start_req || (st_ff.cs != SAS_IDLE) ||
                   (st_ff.sync != 2'h0);
      res_lo = st_ff.adj ? {st_ff.res[1:0], 6'h00} : st_ff.res[7:0];
      res_hi = st_ff.adj ? st_ff.res[9:2] : {6'h00, st_ff.res[9:8]};
      if (!st_ff.en)
      begin
         nxt_st.pre = 8'h00;
         nxt_st.hr = 1'b0;
         nxt_st.aclk = 1'b0;
      end
      else if (rise)
      begin
         nxt_st.pre = 8'h00;
         nxt_st.hr = !st_ff.hr;
         nxt_st.aclk = 1'b1;
      end
      else
      begin
         nxt_st.pre = st_ff.pre + 8'h01;
         if (fall)
            nxt_st.aclk = 1'b0;
      end
      // Trigger edge detect on selected source
      tsig = (st_ff.tsrc == 3'h0) ? 1'b0 : trig_src_i[st_ff.tsrc - 3'h1];
      tedge = tsig && !st_ff.trig_prev;
      nxt_st.trig_prev = tsig;

      // Write channel: address and data in either order
      if (s_axi_awvalid && st_ff.awrdy)
      begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_ff.wrdy)
      begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = s_axi_wdata[7:0];
         nxt_st.wstb = s_axi_wstrb[0];
      end
      if (st_ff.bvalid && s_axi_bready)
         nxt_st.bvalid = 1'b0;
      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
      begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = RESP_OKAY;
         unique case (st_ff.awaddr)
            OFF_CTRL:
               if (st_ff.wstb)
               begin
                  nxt_st.en = st_ff.wdata[CTL_EN];
                  nxt_st.auto = st_ff.wdata[CTL_AUTO];
                  nxt_st.ie = st_ff.wdata[CTL_IE];
                  nxt_st.div = st_ff.wdata[2:0];
                  if (st_ff.wdata[CTL_START] && st_ff.wdata[CTL_EN])
                     nxt_st.start_req = 1'b1;
                  if (st_ff.wdata[CTL_DONE])
                     nxt_st.done = 1'b0;
               end
            OFF_CHAN:
               if (st_ff.wstb)
               begin
                  nxt_st.ch = st_ff.wdata[4:0];
                  nxt_st.adj = st_ff.wdata[CH_ADJ];
                  nxt_st.refs = st_ff.wdata[CH_REF +: 2];
               end
            OFF_TRIG:
               if (st_ff.wstb)
                  nxt_st.tsrc = st_ff.wdata[2:0];
            OFF_RES_LO, OFF_RES_HI:
               nxt_st.bresp = RESP_OKAY;
            default:
               nxt_st.bresp = RESP_SLVERR;
         endcase
      end
      nxt_st.awrdy = !nxt_st.aw_got && !nxt_st.bvalid;
      nxt_st.wrdy = !nxt_st.w_got && !nxt_st.bvalid;

      // Read channel
      if (st_ff.rvalid && s_axi_rready)
         nxt_st.rvalid = 1'b0;
      if (s_axi_arvalid && st_ff.arrdy)
      begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = RESP_OKAY;
         unique case (s_axi_araddr)
            OFF_CTRL:
               nxt_st.rdata = {st_ff.en, start_view, st_ff.auto,
                               st_ff.done, st_ff.ie, st_ff.div};
            OFF_CHAN:
               nxt_st.rdata = {st_ff.refs, st_ff.adj, st_ff.ch};
            OFF_TRIG:
               nxt_st.rdata = {5'h00, st_ff.tsrc};
            OFF_RES_LO:
            begin
               nxt_st.rdata = res_lo;
               // low byte read locks the pair
               nxt_st.lock = 1'b1;
            end
            OFF_RES_HI:
            begin
               nxt_st.rdata = res_hi;
               nxt_st.lock = 1'b0;
            end
            default:
            begin
               nxt_st.rdata = 8'h00;
               nxt_st.rresp = RESP_SLVERR;
            end
         endcase
      end
      nxt_st.arrdy = !nxt_st.rvalid;

      // Conversion sequencing
      unique case (st_ff.cs)
         SAS_IDLE:
         begin
            if (st_ff.sync != 2'h0)
            begin
               nxt_st.sync = st_ff.sync + 2'h1;
               // prescaler reset and start after sync
               if (st_ff.sync == TRIG_SYNC_LAST)
               begin
                  nxt_st.sync = 2'h0;
                  nxt_st.pre = 8'h00;
                  nxt_st.hr = 1'b0;
                  nxt_st.aclk = 1'b0;
                  nxt_st.cs = SAS_CONV;
                  nxt_st.half = 6'h00;
                  nxt_st.sh_seen = 1'b0;
                  {nxt_st.end_h, nxt_st.sh_h} =
                     sas_timing(st_ff.first, 1'b1, diff, 1'b0);
               end
            end
            else if (st_ff.start_req)
               nxt_st.cs = SAS_WAIT_EDGE;
            // only a fresh edge while idle arms a start
            else if (st_ff.auto && tedge)
               nxt_st.sync = 2'h1;
         end
         SAS_WAIT_EDGE:
            // begin on next rising converter edge
            if (rise)
            begin
               nxt_st.cs = SAS_CONV;
               nxt_st.half = 6'h00;
               nxt_st.sh_seen = 1'b0;
               // length by first, differential, half rate
               {nxt_st.end_h, nxt_st.sh_h} =
                  sas_timing(st_ff.first, 1'b0, diff, st_ff.hr);
            end
         SAS_CONV:
            if (rise || fall)
            begin
               nxt_st.half = st_ff.half + 6'h01;
               if (st_ff.half + 6'h01 == st_ff.sh_h)
               begin
                  nxt_st.sh = 1'b1;
                  nxt_st.sh_seen = 1'b1;
               end
               if (st_ff.half + 6'h01 == st_ff.end_h)
                  complete = 1'b1;
            end
      endcase

      // completion: result unless locked, flag always
      if (complete)
      begin
         if (!nxt_st.lock)
            nxt_st.res = result_i;
         nxt_st.done = 1'b1;
         nxt_st.first = 1'b0;
         // own flag as source restarts at once
         if (st_ff.auto && st_ff.tsrc == 3'h0)
         begin
            nxt_st.half = 6'h00;
            nxt_st.sh_seen = 1'b0;
            {nxt_st.end_h, nxt_st.sh_h} =
               sas_timing(1'b0, 1'b0, diff, 1'b1);
         end
         else
         begin
            nxt_st.cs = SAS_IDLE;
            nxt_st.start_req = 1'b0;
         end
      end

      // disable aborts and rearms first conversion
      // Next value, so a start written with enable is kept
      if (!nxt_st.en)
      begin
         nxt_st.cs = SAS_IDLE;
         nxt_st.sync = 2'h0;
         nxt_st.start_req = 1'b0;
         nxt_st.first = 1'b1;
      end
      // selection tracks only when idle or final cycle
      if (st_ff.en && (st_ff.cs != SAS_CONV || final_cyc))
      begin
         nxt_st.live_ch = st_ff.ch;
         nxt_st.live_ref = st_ff.refs;
      end
      // gain stage bypassed only for single-ended channels
      nxt_st.bypass = (nxt_st.live_ch <= SE_LAST);
      if (nxt_st.live_ch >= GAIN200_FIRST && nxt_st.live_ch <= GAIN_LAST)
         nxt_st.gain = GAIN_200X;
      else if (nxt_st.live_ch >= GAIN10_FIRST &&
               nxt_st.live_ch < GAIN200_FIRST)
         nxt_st.gain = GAIN_10X;
      else
         nxt_st.gain = GAIN_1X;
      nxt_st.irq = nxt_st.done && nxt_st.ie;
      nxt_st.busy = (nxt_st.cs == SAS_CONV);
   end

   // State register
   always_ff @(posedge clk_sys_i)
   begin
      if (!nrst_i)
      begin
         st_ff <= '0;
         st_ff.first <= 1'b1;
      end
      else
         st_ff <= nxt_st;
   end

   // Outputs straight from state
   assign s_axi_awready = st_ff.awrdy;
   assign s_axi_wready  = st_ff.wrdy;
   assign s_axi_bresp   = st_ff.bresp;
   assign s_axi_bvalid  = st_ff.bvalid;
   assign s_axi_arready = st_ff.arrdy;
   assign s_axi_rdata   = {24'h000000, st_ff.rdata};
   assign s_axi_rresp   = st_ff.rresp;
   assign s_axi_rvalid  = st_ff.rvalid;
   assign power_en_o    = st_ff.en;
   assign mux_sel_o     = st_ff.live_ch;
   assign ref_sel_o     = st_ff.live_ref;
   assign gain_sel_o    = st_ff.gain;
   assign gain_bypass_o = st_ff.bypass;
   assign sample_hold_o = st_ff.sh;
   assign adc_clk_o     = st_ff.aclk;
   assign conv_busy_o   = st_ff.busy;
   assign done_irq_o    = st_ff.irq;

   // ************************************************************
   // Checks
   // ************************************************************
   a_lock_holds: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff.lock && nxt_st.lock) |=> $stable(st_ff.res))
      else $error("result changed while locked");
   a_done_at_end: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      complete |=> st_ff.done)
      else $error("done flag missing after completion");
   a_start_busy: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff.cs == SAS_CONV) |-> start_view)
      else $error("start bit low during conversion");
   a_sel_frozen: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff.cs == SAS_CONV && !final_cyc) |=> $stable(st_ff.live_ch))
      else $error("channel moved mid conversion");
   a_pre_reset: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      !st_ff.en |=> (st_ff.pre == 8'h00 && !st_ff.aclk))
      else $error("prescaler ran while disabled");
   a_hold_first: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      complete |-> st_ff.sh_seen)
      else $error("conversion ended without hold");
   a_free_run: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (complete && nxt_st.en && st_ff.auto && st_ff.tsrc == 3'h0)
      |=> (st_ff.cs == SAS_CONV && st_ff.half == 6'h00))
      else $error("free running did not restart");
   a_edge_ignored: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff.cs == SAS_CONV) |=> (st_ff.sync == 2'h0))
      else $error("trigger armed during conversion");
   a_trig_sync: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff.sync == 2'h1 && st_ff.en) |=> ##1 (st_ff.cs == SAS_CONV))
      else $error("trigger start not after three cycles");
   a_irq_follow: assert property (
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (st_ff.done && st_ff.ie) |-> st_ff.irq)
      else $error("interrupt request missing");
endmodule // sas_top
`default_nettype wire

// >>> tb/sas_afe_model.sv
// Comparator array stand-in: holds a fresh code at each hold pulse.
// Assumes the sequencer's analog-side ports on one system clock.
`timescale 1ns/1ps
`default_nettype none
module sas_afe_model
(
   input  wire logic       clk_sys_i,  // System clock
   input  wire logic       power_en_i, // Analog power on
   input  wire logic       hold_i,     // Hold pulse
   input  wire logic [4:0] mux_i,      // Applied channel
   output logic [9:0]      result_o,   // Code to the sequencer
   output logic [9:0]      held_o      // Held code, for the bench
);
   logic [9:0] noise_ff = 10'h2a5;
   // Code mixes channel and a value that moves every cycle
   always @(posedge clk_sys_i)
   begin
      noise_ff <= noise_ff + 10'h1b7;
      if (hold_i && power_en_i) held_o <= {mux_i, noise_ff[4:0]};
   end
   // Unpowered array shows no stable code
   assign result_o = power_en_i ? held_o : noise_ff;
endmodule // sas_afe_model
`default_nettype wire

// >>> tb/sar_adc_sequencer_tb.sv
// Self-checking bench: bus tasks, scoreboard of conversions.
// Assumes sas_pkg, sas_top and sas_afe_model compiled first.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_tb;
   import sas_pkg::*;
   logic clk_sys_i = 0, nrst_i = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0, ch, mux_sel_o;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [6:0] trig_src_i = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, power_en_o, gain_bypass_o, sample_hold_o;
   logic adc_clk_o, conv_busy_o, done_irq_o;
   logic [1:0] s_axi_bresp, s_axi_rresp, ref_sel_o, gain_sel_o, r;
   logic [9:0] result_i, held, exp_res;
   logic [4:0] gcode[3] = '{5'h09, 5'h0d, 5'h03};
   logic [2:0] gexp[3] = '{3'h1, 3'h2, 3'h4};
   int num_errors = 0, checks_done = 0, cyc = 0, blen = 0, bsh = 0;
   int lock_m = 0, n_hold = 0, nh;
   int len_q[$], sh_q[$];
   sas_top sas_top_inst (.clk_sys_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .trig_src_i, .result_i, .power_en_o, .mux_sel_o, .ref_sel_o, .gain_sel_o,
      .gain_bypass_o, .sample_hold_o, .adc_clk_o, .conv_busy_o, .done_irq_o);
   sas_afe_model sas_afe_model_inst (.clk_sys_i, .power_en_i(power_en_o),
      .hold_i(sample_hold_o), .mux_i(mux_sel_o), .result_o(result_i),
      .held_o(held));
   // 20 MHz system clock
   initial forever #25 clk_sys_i = ~clk_sys_i;
   task automatic chk(input string n, input logic [31:0] s, e);
      checks_done++;
      if (s !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Timeout, conversion length, hold point and model result
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         num_errors++;
         tally_and_finish;
      end
      if (sample_hold_o === 1'b1)
      begin
         bsh = blen;
         n_hold++;
      end
      if (conv_busy_o === 1'b1) blen++;
      else if (blen > 0)
      begin
         len_q.push_back(blen);
         sh_q.push_back(bsh);
         if (lock_m == 0) exp_res = held;
         blen = 0;
      end
   end
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk_sys_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a);
      @(posedge clk_sys_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_sys_i);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (a == OFF_RES_LO) lock_m = 1;
      if (a == OFF_RES_HI) lock_m = 0;
   endtask
   function automatic logic [7:0] fmt(input logic [9:0] v, input logic adj, hi);
      logic [15:0] w;
      w = adj ? {v, 6'h00} : {6'h00, v};
      return hi ? w[15:8] : w[7:0];
   endfunction
   task automatic chk_res(input logic adj);
      rd(OFF_RES_LO);
      chk("res_lo", d, {24'h0, fmt(exp_res, adj, 0)});
      rd(OFF_RES_HI);
      chk("res_hi", d, {24'h0, fmt(exp_res, adj, 1)});
   endtask
   task automatic wait_conv;
      int n;
      n = len_q.size();
      while (len_q.size() == n) @(posedge clk_sys_i);
      repeat (2) @(posedge clk_sys_i);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial
   begin
      void'($urandom(32'hf6b0));
      ch = 5'($urandom % 8);
      repeat (3) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      rd(OFF_CTRL);
      chk("ctrl_rst", d, 0);
      rd(5'h14);
      chk("unmap_d", d, 32'h0);
      chk("unmap_r", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(5'h14, 32'hff);
      chk("unmap_b", {30'h0, r}, {30'h0, RESP_SLVERR});
      // First conversion after enable, random channel
      wr(OFF_CHAN, {27'h0, ch});
      wr(OFF_CTRL, 32'hc0);
      wait (conv_busy_o === 1'b1);
      rd(OFF_CTRL);
      chk("start_busy", d[6], 1);
      wait_conv;
      rd(OFF_CTRL);
      chk("start_clr", d[7:4], 4'h9);
      chk_res(0);
      chk("bypass", {gain_bypass_o, mux_sel_o}, {1'b1, ch});
      // Normal conversion, left adjust, channel change meanwhile
      wr(OFF_CHAN, 32'h22);
      wr(OFF_CTRL, 32'hd0);
      repeat (4) @(posedge clk_sys_i);
      wr(OFF_CHAN, 32'h29);
      chk("mux_hold", mux_sel_o, 5'h02);
      wait_conv;
      chk_res(1);
      chk("mux_new", mux_sel_o, 5'h09);
      chk("len", len_q[0] - len_q[1], 24);
      chk("sh", sh_q[0] - sh_q[1], 24);
      chk("tail", len_q[1] - sh_q[1], 23);
      foreach (gcode[i])
      begin
         wr(OFF_CHAN, {27'h0, gcode[i]});
         repeat (2) @(posedge clk_sys_i);
         chk("gain", {gain_bypass_o, gain_sel_o}, gexp[i]);
      end
      wr(OFF_CHAN, 32'hc3);
      repeat (2) @(posedge clk_sys_i);
      chk("ref", ref_sel_o, 2'h3);
      // Low byte read locks the pair; flag and request still rise
      wr(OFF_CTRL, 32'hd8);
      wait_conv;
      rd(OFF_RES_LO);
      chk("lo", d, {24'h0, fmt(exp_res, 0, 0)});
      wr(OFF_CTRL, 32'hd8);
      wait_conv;
      chk("irq", done_irq_o, 1);
      rd(OFF_RES_HI);
      chk("hi_lock", d, {24'h0, fmt(exp_res, 0, 1)});
      wr(OFF_CTRL, 32'h98);
      repeat (3) @(posedge clk_sys_i);
      chk("irq_clr", done_irq_o, 0);
      // Auto trigger on source 1, extra edge and held level
      wr(OFF_TRIG, 32'h1);
      wr(OFF_CTRL, 32'hb0);
      trig_src_i <= 7'h01;
      wait (conv_busy_o === 1'b1);
      repeat (6) @(posedge clk_sys_i);
      // source lowered and raised again by the bench
      trig_src_i <= 7'h00;
      @(posedge clk_sys_i);
      trig_src_i <= 7'h01;
      wait_conv;
      chk("auto_tail", len_q[$] - sh_q[$], 23);
      chk_res(0);
      nh = len_q.size();
      wr(OFF_CTRL, 32'hf0);
      wait_conv;
      repeat (80) @(posedge clk_sys_i);
      chk("auto_n", len_q.size(), nh + 1);
      // Own done flag as source: continuous conversions
      wr(OFF_TRIG, 32'h0);
      nh = n_hold;
      wr(OFF_CTRL, 32'he0);
      while (n_hold < nh + 3) @(posedge clk_sys_i);
      rd(OFF_CTRL);
      chk("free_start", d[6], 1);
      wr(OFF_CTRL, 32'h00);
      repeat (2) @(posedge clk_sys_i);
      chk("off", {power_en_o, conv_busy_o, adc_clk_o}, 0);
      // Divide by four, first conversion again after re-enable
      wr(OFF_CTRL, 32'hc2);
      wait_conv;
      chk("div_tail", len_q[$] - sh_q[$], 46);
      chk_res(0);
      tally_and_finish;
   end
endmodule // sar_adc_sequencer_tb
`default_nettype wire
